// file: verilog/srta_pkg.sv
package srta_pkg;
    // ************************************************************
    // Command numbers (decimal as printed)
    // ************************************************************
    localparam logic [15:0] CMD_RD_REG = 16'd6101;   // Read into host register table
    localparam logic [15:0] CMD_RD_INP = 16'd6102;   // Read into host input table
    localparam logic [15:0] CMD_WR_REG = 16'd6111;   // Write from host register table
    localparam logic [15:0] CMD_WR_OUT = 16'd6113;   // Write from host output table
    // ************************************************************
    // Memory types
    // ************************************************************
    localparam logic [15:0] MEM_REG = 16'd1;         // Register memory incl. accumulators
    localparam logic [15:0] MEM_IO = 16'd3;          // Discrete I/O points
    // ************************************************************
    // Address map
    // ************************************************************
    localparam logic [15:0] ADDR_TC0 = 16'd65;       // Timer/counter 0 (reference 200)
    localparam logic [15:0] ADDR_IO7000 = 16'd89;    // Internal point 7000
    localparam int IO7000_BASE = 64;                 // Bit index of point 7000 in I/O array
    // ************************************************************
    // Command block word indices
    // ************************************************************
    localparam logic [2:0] W_CMD = 3'h0;             // Command number
    localparam logic [2:0] W_ID = 3'h1;              // Target station ID
    localparam logic [2:0] W_MTYPE = 3'h2;           // Target memory type
    localparam logic [2:0] W_TADDR = 3'h3;           // Target start address
    localparam logic [2:0] W_LEN = 3'h4;             // Data length
    localparam logic [2:0] W_SADDR = 3'h5;           // Host source start address
    localparam logic [2:0] W_LAST = 3'h5;            // Last header word
    // Answer status codes
    localparam logic [1:0] ST_OK = 2'h0;             // Accepted
    localparam logic [1:0] ST_BAD = 2'h1;            // Rejected, no change made
    localparam logic [1:0] ST_NOID = 2'h2;           // Not addressed to this station
endpackage : srta_pkg

// file: verilog/srta_if.sv
`timescale 1ns/1ps
// ************************************************************
// Word link between host and target, valid/ready both ways
// ************************************************************
interface srta_if;
    logic [15:0] req_data;   // Host to target word
    logic req_valid;         // Host word valid
    logic req_ready;         // Target takes word
    logic req_last;          // Last word of request
    logic [15:0] rsp_data;   // Target to host word
    logic rsp_valid;         // Target word valid
    logic rsp_ready;         // Host takes word
    logic rsp_last;          // Last word of answer
    logic [1:0] rsp_status;  // Status, valid with rsp_last
    modport target (input req_data, req_valid, req_last, rsp_ready,
                    output req_ready, rsp_data, rsp_valid, rsp_last, rsp_status);
    modport host (output req_data, req_valid, req_last, rsp_ready,
                  input req_ready, rsp_data, rsp_valid, rsp_last, rsp_status);
endinterface : srta_if

// file: verilog/srta_target.sv
`timescale 1ns/1ps
module srta_target #(
    parameter int N_ACC = 64,                 // Number of accumulators
    parameter int N_IO = 512,                 // Number of discrete points
    parameter logic [15:0] STATION_ID = 16'd10 // Own station ID
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    srta_if.target bus,
    input wire logic [N_ACC-1:0] i_acc_used,     // Accumulator referenced by user logic
    input wire logic [N_ACC-1:0] i_acc_is_ctr,   // Referenced as counter, else timer
    input wire logic [N_ACC-1:0] i_acc_enable,   // Timer input closed / counter pulse
    input wire logic [N_ACC-1:0] i_acc_reset,    // Timer or counter reset input
    input wire logic [N_ACC*16-1:0] i_acc_preset, // Programmed presets
    input wire logic [N_IO-1:0] i_io_in,         // Scanned I/O image
    output logic [N_ACC*16-1:0] o_acc,           // Accumulator values
    output logic [N_ACC-1:0] o_acc_done,         // Timed or counted out
    output logic [N_IO-1:0] o_io                 // I/O image as written
);
    // ************************************************************
    // State machine
    // ************************************************************
    typedef enum logic [3:0] {
        S_HDR = 4'b0001,   // Collect header words
        S_DATA = 4'b0010,  // Take write data
        S_RSP = 4'b0100,   // Return read data
        S_END = 4'b1000    // Status word
    } srta_state_t;
    srta_state_t state_q;
    logic [15:0] hdr_q [6];       // Header words
    logic [2:0] widx_q;           // Header word index
    logic [15:0] cnt_q;           // Items left
    logic [15:0] pos_q;           // Current target index
    logic [1:0] stat_q;           // Answer status
    logic [15:0] hold_q;          // Data word for responses
    logic drain_q;                // Reject: swallow remaining words
    logic disp_q;                 // Header complete, dispatch pending
    logic acc_wr;                 // Accumulator write strobe
    logic io_wr;                  // I/O bit write strobe
    logic [15:0] tgt_base;        // Start index of addressed area
    logic cmd_ok;                 // Command and type legal
    logic is_wr;                  // Write command
    logic is_io;                  // I/O memory type
    logic [15:0] w_cmd;
    logic [15:0] w_typ;
    logic req_fire;
    logic rsp_fire;

    assign req_fire = bus.req_valid && bus.req_ready;
    assign rsp_fire = bus.rsp_valid && bus.rsp_ready;
    assign w_cmd = hdr_q[srta_pkg::W_CMD];
    assign w_typ = hdr_q[srta_pkg::W_MTYPE];
    // Decode of command and memory type
    always_comb begin
        is_wr = (w_cmd == srta_pkg::CMD_WR_REG) || (w_cmd == srta_pkg::CMD_WR_OUT);
        is_io = (w_typ == srta_pkg::MEM_IO);
        cmd_ok = ((w_cmd == srta_pkg::CMD_RD_REG) || (w_cmd == srta_pkg::CMD_WR_REG)
                 || (w_cmd == srta_pkg::CMD_RD_INP) || (w_cmd == srta_pkg::CMD_WR_OUT))
                 && ((w_typ == srta_pkg::MEM_REG) || is_io);
        if (is_io) begin
            // Address 89 is point 7000, lower addresses count points from 1
            if (hdr_q[srta_pkg::W_TADDR] >= srta_pkg::ADDR_IO7000) begin
                tgt_base = 16'(srta_pkg::IO7000_BASE) + hdr_q[srta_pkg::W_TADDR]
                           - srta_pkg::ADDR_IO7000;
            end else begin
                tgt_base = hdr_q[srta_pkg::W_TADDR] - 16'd1;
            end
        end else begin
            tgt_base = hdr_q[srta_pkg::W_TADDR] - srta_pkg::ADDR_TC0;
        end
    end

    // ************************************************************
    // Link handshake
    // ************************************************************
    assign bus.req_ready = (state_q == S_HDR) || (state_q == S_DATA);
    // Status word is held back during the dispatch cycle
    assign bus.rsp_valid = (state_q == S_RSP) || (state_q == S_END && !disp_q);
    assign bus.rsp_last = (state_q == S_END) && !disp_q;
    assign bus.rsp_data = hold_q;
    assign bus.rsp_status = stat_q;
    assign acc_wr = req_fire && (state_q == S_DATA) && !drain_q && !is_io;
    assign io_wr = req_fire && (state_q == S_DATA) && !drain_q && is_io;

    // Sequencer over command block, data and answer
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= S_HDR;
            for (int k = 0; k < 6; k++) begin
                hdr_q[k] <= 16'h0000;
            end
            widx_q <= 3'h0;
            cnt_q <= 16'h0000;
            pos_q <= 16'h0000;
            stat_q <= srta_pkg::ST_OK;
            hold_q <= 16'h0000;
            drain_q <= 1'b0;
            disp_q <= 1'b0;
        end else begin
            unique case (state_q)
                S_HDR: begin
                    // Words arrive in block order
                    if (req_fire) begin
                        hdr_q[widx_q] <= bus.req_data;
                        widx_q <= widx_q + 3'h1;
                        if (widx_q == srta_pkg::W_LAST) begin
                            widx_q <= 3'h0;
                            state_q <= S_END;
                            disp_q <= 1'b1;
                            stat_q <= srta_pkg::ST_OK;
                            drain_q <= 1'b0;
                            hold_q <= 16'h0000;
                            cnt_q <= hdr_q[srta_pkg::W_LEN];
                        end
                    end
                end
                S_DATA: begin
                    if (req_fire) begin
                        if (is_io) begin
                            pos_q <= pos_q + 16'h1;
                            cnt_q <= cnt_q - 16'h1;
                        end else begin
                            pos_q <= pos_q + 16'h1;
                            cnt_q <= cnt_q - 16'h1;
                        end
                        if (bus.req_last || cnt_q == 16'h1) begin
                            state_q <= S_END;
                        end
                    end
                end
                S_RSP: begin
                    if (rsp_fire) begin
                        pos_q <= pos_q + 16'h1;
                        cnt_q <= cnt_q - 16'h1;
                        if (cnt_q == 16'h1) begin
                            state_q <= S_END;
                            hold_q <= 16'h0000;
                        end else if (is_io) begin
                            hold_q <= {15'h0000, i_io_in[(pos_q + 16'h1) % N_IO]};
                        end else begin
                            hold_q <= o_acc[((pos_q + 16'h1) % N_ACC)*16 +: 16];
                        end
                    end
                end
                S_END: begin
                    if (rsp_fire) begin
                        state_q <= S_HDR;
                        hdr_q[srta_pkg::W_CMD] <= 16'h0000;
                    end
                end
                default: state_q <= S_HDR;
            endcase
            // Dispatch one cycle after the header completes, all six words held
            if (disp_q) begin
                disp_q <= 1'b0;
                pos_q <= tgt_base;
                if (hdr_q[srta_pkg::W_ID] != STATION_ID) begin
                    stat_q <= srta_pkg::ST_NOID;
                    drain_q <= is_wr;
                    state_q <= (is_wr && cnt_q != 16'h0000) ? S_DATA : S_END;
                end else if (!cmd_ok) begin
                    stat_q <= srta_pkg::ST_BAD;
                    drain_q <= is_wr;
                    state_q <= (is_wr && cnt_q != 16'h0000) ? S_DATA : S_END;
                end else if (cnt_q == 16'h0000) begin
                    // Nothing to move: answer with status at once
                    state_q <= S_END;
                end else if (is_wr) begin
                    state_q <= S_DATA;
                end else begin
                    state_q <= S_RSP;
                    // Point n lands in host input n+1, first item preloaded
                    hold_q <= is_io ? {15'h0000, i_io_in[tgt_base % N_IO]}
                                    : o_acc[(tgt_base % N_ACC)*16 +: 16];
                end
            end
        end
    end

    // ************************************************************
    // Accumulators with timer/counter interaction
    // ************************************************************
    generate
        for (genvar g = 0; g < N_ACC; g++) begin : g_acc
            logic [15:0] acc_q;   // Accumulator value
            logic done_q;         // Timed or counted out
            logic en_q;           // Previous enable for counter edge
            logic hit;            // Host writes this accumulator
            logic [15:0] pre;
            assign pre = i_acc_preset[g*16 +: 16];
            assign hit = acc_wr && (pos_q == 16'(g));
            assign o_acc[g*16 +: 16] = acc_q;
            assign o_acc_done[g] = done_q;
            // Host data byte lanes copied straight across
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    acc_q <= 16'h0000;
                    done_q <= 1'b0;
                    en_q <= 1'b0;
                end else begin
                    en_q <= i_acc_enable[g];
                    if (!i_acc_used[g]) begin
                        if (hit) acc_q <= bus.req_data;
                        done_q <= 1'b0;
                    end else if (i_acc_reset[g]) begin
                        acc_q <= pre;
                        done_q <= 1'b0;
                    end else if (!i_acc_is_ctr[g] && !i_acc_enable[g]) begin
                        acc_q <= pre;
                        done_q <= 1'b0;
                    end else if (hit) begin
                        acc_q <= bus.req_data;
                    end else if (!done_q) begin
                        if (i_acc_is_ctr[g] ? (i_acc_enable[g] && !en_q) : 1'b1) begin
                            if (acc_q <= 16'h1) begin
                                acc_q <= 16'h0000;
                                done_q <= 1'b1;
                            end else begin
                                acc_q <= acc_q - 16'h1;
                            end
                        end
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // Discrete I/O image
    // ************************************************************
    generate
        for (genvar p = 0; p < N_IO; p++) begin : g_io
            logic io_q;
            assign o_io[p] = io_q;
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    io_q <= 1'b0;
                end else if (io_wr && pos_q == 16'(p)) begin
                    io_q <= bus.req_data[0];
                end
            end
        end
    endgenerate
endmodule : srta_target

// file: verilog/srta_host.sv
`timescale 1ns/1ps
// ************************************************************
// Host end: sends a command block, streams or collects data
// ************************************************************
module srta_host (
    input wire logic i_clk,
    input wire logic i_rst_b,
    srta_if.host bus,
    input wire logic i_start,            // Pulse: issue serial_request_op
    input wire logic [95:0] i_block,     // Six words, word 0 in low bits
    input wire logic i_wr_valid,         // Staged write word available
    input wire logic [15:0] i_wr_data,   // Register word or output bit in bit 0
    output logic o_wr_ready,             // Host takes staged word
    output logic o_rd_valid,             // Read word returned
    output logic [15:0] o_rd_data,       // Returned register or input bit
    output logic o_busy,                 // Request in progress
    output logic o_done,                 // Pulse at end
    output logic [1:0] o_status          // Final status
);
    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,  // Waiting
        H_HDR = 4'b0010,   // Sending block
        H_DATA = 4'b0100,  // Sending staged data
        H_RSP = 4'b1000    // Collecting answer
    } srta_hstate_t;
    srta_hstate_t state_q;
    logic [95:0] blk_q;      // Latched command block
    logic [2:0] idx_q;       // Header word index
    logic [15:0] left_q;     // Data words left
    logic is_wr;
    logic [15:0] cmd;
    assign cmd = blk_q[15:0];
    // write commands send data after the block
    assign is_wr = (cmd == srta_pkg::CMD_WR_REG) || (cmd == srta_pkg::CMD_WR_OUT);
    assign bus.req_valid = (state_q == H_HDR) || (state_q == H_DATA && i_wr_valid);
    assign bus.req_data = (state_q == H_HDR) ? blk_q[idx_q*16 +: 16] : i_wr_data;
    // Last word: final data word, or final header word when no data follows
    assign bus.req_last = ((state_q == H_DATA) && (left_q == 16'h1))
                          || ((state_q == H_HDR) && (idx_q == srta_pkg::W_LAST)
                          && !(is_wr && left_q != 16'h0));
    assign bus.rsp_ready = (state_q == H_RSP);
    assign o_wr_ready = (state_q == H_DATA) && bus.req_ready;
    assign o_busy = (state_q != H_IDLE);

    // Sequencer; block latched at start, data words wait for i_wr_valid
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= H_IDLE;
            blk_q <= 96'h0;
            idx_q <= 3'h0;
            left_q <= 16'h0000;
            o_rd_valid <= 1'b0;
            o_rd_data <= 16'h0000;
            o_done <= 1'b0;
            o_status <= srta_pkg::ST_OK;
        end else begin
            o_rd_valid <= 1'b0;
            o_done <= 1'b0;
            unique case (state_q)
                H_IDLE: begin
                    if (i_start) begin
                        blk_q <= i_block;
                        idx_q <= 3'h0;
                        left_q <= i_block[srta_pkg::W_LEN*16 +: 16];
                        state_q <= H_HDR;
                    end
                end
                H_HDR: begin
                    if (bus.req_ready) begin
                        idx_q <= idx_q + 3'h1;
                        if (idx_q == srta_pkg::W_LAST) begin
                            state_q <= (is_wr && left_q != 16'h0) ? H_DATA : H_RSP;
                        end
                    end
                end
                H_DATA: begin
                    if (bus.req_ready && i_wr_valid) begin
                        left_q <= left_q - 16'h1;
                        if (left_q == 16'h1) state_q <= H_RSP;
                    end
                end
                H_RSP: begin
                    if (bus.rsp_valid) begin
                        if (bus.rsp_last) begin
                            o_status <= bus.rsp_status;
                            o_done <= 1'b1;
                            state_q <= H_IDLE;
                        end else begin
                            o_rd_valid <= 1'b1;
                            o_rd_data <= bus.rsp_data;
                        end
                    end
                end
            endcase
        end
    end
endmodule : srta_host

// file: tb/srta_chk.sv
`timescale 1ns/1ps
// ****************************************
// Link checker between host and target
// ****************************************
module srta_chk (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [15:0] req_data,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_last,
    input wire logic [15:0] rsp_data,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic rsp_last,
    input wire logic [1:0] rsp_status
);
    logic [15:0] idx_q, cmd_q, len_q, nrsp_q; // Word index, command, length, answer words
    logic wait_q; // Request complete, answer pending
    wire logic rq_hs = req_valid && req_ready; // Request word taken
    wire logic rs_end = rsp_valid && rsp_ready && rsp_last; // Status word taken
    wire logic is_rd = (cmd_q == srta_pkg::CMD_RD_REG) || (cmd_q == srta_pkg::CMD_RD_INP);
    wire logic is_wr = (cmd_q == srta_pkg::CMD_WR_REG) || (cmd_q == srta_pkg::CMD_WR_OUT);
    // Count words of each transaction
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            idx_q <= 16'h0;
            nrsp_q <= 16'h0;
            wait_q <= 1'b0;
        end else begin
            idx_q <= rs_end ? 16'h0 : idx_q + {15'h0, rq_hs};
            nrsp_q <= rs_end ? 16'h0 : nrsp_q + {15'h0, rsp_valid && rsp_ready};
            wait_q <= rs_end ? 1'b0 : (wait_q || (rq_hs && req_last));
        end
    end
    // Keep command and length words of the header
    always_ff @(posedge i_clk) begin
        if (rq_hs && idx_q == 16'h0) cmd_q <= req_data;
        if (rq_hs && idx_q == 16'h4) len_q <= req_data;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_req_end;
        rq_hs && req_last;
    endsequence
    sequence s_rsp_ok;
        rs_end && rsp_status == srta_pkg::ST_OK;
    endsequence
    req_hold_a: assert property (
        req_valid && !req_ready |=> req_valid && $stable(req_data) && $stable(req_last))
        else $error("request word changed before taken");
    rsp_hold_a: assert property (
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last))
        else $error("answer word changed before taken");
    req_pos_a: assert property (
        s_req_end and (is_rd || is_wr) |-> idx_q == (is_rd ? 16'd5 : 16'd5 + len_q))
        else $error("request length wrong");
    rsp_cnt_a: assert property (
        s_rsp_ok |-> nrsp_q == (is_rd ? len_q : 16'h0))
        else $error("answer word count wrong");
    bad_code_a: assert property (
        rs_end && !(is_rd || is_wr) |-> rsp_status != srta_pkg::ST_OK)
        else $error("unknown command accepted");
    rsp_due_a: assert property (s_req_end |-> ##[1:40] rsp_valid)
        else $error("no answer after request");
    no_early_a: assert property (rsp_valid |-> wait_q)
        else $error("answer before request complete");
    no_overlap_a: assert property (wait_q |-> !rq_hs)
        else $error("request word taken while answer pending");
endmodule : srta_chk

// file: tb/serial_request_target_access_tb.sv
`timescale 1ns/1ps
// ****************************************
// Host to target end-to-end bench
// ****************************************
module serial_request_target_access_tb;
    localparam logic [15:0] ID = 16'h000a; // Own station number of the target
    localparam logic [7:0] IO_PAT = 8'h3c; // Output pattern sent to points 7000 up
    logic i_clk = 1'b0, i_rst_b = 1'b0, h_start, h_wr_valid, h_wr_ready, h_rd_valid, h_done;
    logic [95:0] h_block; // Command block, word 0 low
    logic [15:0] h_wr_data, h_rd_data, wq[8], rq[8]; // Staged and returned words
    logic [1:0] h_status;
    logic h_busy; // Host request in progress
    logic [3:0] used, is_ctr, en, rst, done_o; // Timer/counter controls
    logic [63:0] preset, acc_o; // Presets and accumulators
    logic [127:0] io_in, io_o; // Point images
    int fail_count = 0, n_compared = 0, cyc = 0;
    always #4 i_clk = ~i_clk;
    srta_if link ();
    srta_host srta_host_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(link.host),
        .i_start(h_start), .i_block(h_block), .i_wr_valid(h_wr_valid), .i_wr_data(h_wr_data),
        .o_wr_ready(h_wr_ready), .o_rd_valid(h_rd_valid), .o_rd_data(h_rd_data),
        .o_busy(h_busy), .o_done(h_done), .o_status(h_status));
    srta_target #(.N_ACC(4), .N_IO(128), .STATION_ID(ID)) srta_target_inst (.i_clk(i_clk),
        .i_rst_b(i_rst_b), .bus(link.target), .i_acc_used(used), .i_acc_is_ctr(is_ctr),
        .i_acc_enable(en), .i_acc_reset(rst), .i_acc_preset(preset), .i_io_in(io_in),
        .o_acc(acc_o), .o_acc_done(done_o), .o_io(io_o));
    srta_chk srta_chk_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .req_data(link.req_data),
        .req_valid(link.req_valid), .req_ready(link.req_ready), .req_last(link.req_last),
        .rsp_data(link.rsp_data), .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
        .rsp_last(link.rsp_last), .rsp_status(link.rsp_status));
    // Print counts and verdict, then stop
    task automatic finish_test;
        $display("compared=%0d mismatches=%0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    // Compare one word
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Issue one request, stream wq, collect rq, check final status
    task automatic run(input logic [15:0] cmd, mt, ta, len, sa, input logic [1:0] st,
        input logic [15:0] id = ID);
        int wi, ri, k;
        logic hs, dn, w;
        wi = 0;
        ri = 0;
        dn = 1'b0;
        w = (cmd == srta_pkg::CMD_WR_REG) || (cmd == srta_pkg::CMD_WR_OUT);
        h_block <= {sa, len, ta, mt, id, cmd};
        h_start <= 1'b1;
        h_wr_valid <= w && (len != 16'h0);
        h_wr_data <= wq[0];
        for (k = 0; k < 300 && !dn; k++) begin
            @(negedge i_clk);
            hs = h_wr_valid && h_wr_ready;
            dn = h_done;
            if (h_rd_valid && ri < 8) rq[ri] = h_rd_data;
            if (h_rd_valid) ri++;
            if (dn) chk({14'h0, h_status}, {14'h0, st});
            @(posedge i_clk);
            h_start <= 1'b0;
            if (hs) wi++;
            h_wr_valid <= w && (wi < int'(len));
            h_wr_data <= wq[wi % 8];
        end
        if (!dn) chk(16'hdead, 16'h0);
        chk({15'h0, h_busy}, 16'h0);
    endtask : run
    // Cut a hung run short
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            chk(16'h0, 16'h1);
            finish_test;
        end
    end
    // Main sequence
    initial begin
        int k;
        {h_start, h_wr_valid, h_block, h_wr_data} = '0;
        {used, is_ctr, en, rst} = 16'he28a;
        preset = 64'h1000_0050_0077_0000;
        io_in = {120'h0, 8'ha5};
        wq = '{16'h12ab, 16'h3456, 16'h1111, 16'h0200, 16'h0, 16'h0, 16'h0, 16'h0};
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        rst <= 4'h2; // Timer 3 leaves reset holding its preset, then times
        run(srta_pkg::CMD_WR_REG, srta_pkg::MEM_REG, srta_pkg::ADDR_TC0, 4, 1, 0);
        chk(acc_o[15:0], 16'h12ab);
        chk(acc_o[31:16], 16'h0077);
        chk(acc_o[47:32], 16'h0050);
        chk({15'h0, acc_o[63:48] < 16'h0200 && acc_o[63:48] > 16'h01c0}, 16'h1);
        rst <= 4'h0;
        wq[0] = 16'h0042;
        run(srta_pkg::CMD_WR_REG, srta_pkg::MEM_REG, 16'd66, 1, 1, 0);
        chk(acc_o[31:16], 16'h0042);
        rst <= 4'h8;
        repeat (2) @(posedge i_clk);
        chk(acc_o[63:48], 16'h1000);
        chk({15'h0, done_o[3]}, 16'h0);
        run(srta_pkg::CMD_RD_REG, srta_pkg::MEM_REG, srta_pkg::ADDR_TC0, 2, 1, 0);
        chk(rq[0], 16'h12ab);
        chk(rq[1], 16'h0042);
        run(srta_pkg::CMD_RD_INP, srta_pkg::MEM_IO, 16'd1, 8, 1, 0);
        for (k = 0; k < 8; k++) begin
            chk({15'h0, rq[k][0]}, {15'h0, io_in[k]});
            wq[k] = {15'h0, IO_PAT[k]};
        end
        run(srta_pkg::CMD_WR_OUT, srta_pkg::MEM_IO, srta_pkg::ADDR_IO7000, 8, 33, 0);
        chk({8'h0, io_o[71:64]}, {8'h0, IO_PAT});
        run(16'd6199, srta_pkg::MEM_REG, srta_pkg::ADDR_TC0, 0, 1, 1);
        run(srta_pkg::CMD_WR_REG, 16'd5, srta_pkg::ADDR_TC0, 1, 1, 1);
        chk(acc_o[15:0], 16'h12ab);
        run(srta_pkg::CMD_RD_REG, srta_pkg::MEM_REG, srta_pkg::ADDR_TC0, 1, 1, 2, 16'd11);
        finish_test;
    end
endmodule : serial_request_target_access_tb
